// [logic/nso_defines.svh]
`ifndef NSO_DEFINES_SVH
`define NSO_DEFINES_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define NSO_OFF_FREQ_LO   8'h00
`define NSO_OFF_FREQ_HI   8'h04
`define NSO_OFF_NOM_LO    8'h08
`define NSO_OFF_NOM_HI    8'h0C
`define NSO_OFF_ENABLE    8'h10
`define NSO_OFF_FBINT_LO  8'h14
`define NSO_OFF_FBINT_HI  8'h18
`define NSO_OFF_FBREM     8'h1C
`define NSO_OFF_FBDEN     8'h20
`define NSO_OFF_FBBP      8'h24
`define NSO_OFF_CTRL_TWO  8'h28
`define NSO_OFF_STATUS    8'h2C
`define NSO_OFF_CTRL_FOUR 8'h30
`define NSO_OFF_OUT_EN    8'h34
`define NSO_OFF_OCFG0     8'h38
`define NSO_OFF_PHASE     8'h44

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define NSO_EN_SYNTH_BIT  0
`define NSO_EN_NCO_BIT    1
`define NSO_HS1_LSB       0
`define NSO_HS2_LSB       4
`define NSO_DEC_SRC_LSB   0
`define NSO_INC_SRC_LSB   4
`define NSO_DEC_BIT       8
`define NSO_INC_BIT       9
`define NSO_FMT_LSB       0
`define NSO_INV_BIT       3
`define NSO_DRV_LSB       4

// ---------------------------------------------------------------
// Reset values and fixed figures
// ---------------------------------------------------------------
`define NSO_RST_HSDIV     4'h6
`define NSO_RST_FBBP      6'h09
`define NSO_RST_FBDEN     32'h00000001
`define NSO_FRAC_TOTAL    6'h21

`endif

// [logic/nso_pkg.sv]
package nso_pkg;

	// Output signal formats
	typedef enum logic [2:0] {
		NSO_FMT_OFF       = 3'b000,
		NSO_FMT_CML_FULL  = 3'b001,
		NSO_FMT_CML_HALF  = 3'b010,
		NSO_FMT_HSTL      = 3'b011,
		NSO_FMT_CMOS_P    = 3'b100,
		NSO_FMT_CMOS_PAIR = 3'b101,
		NSO_FMT_CMOS_INV  = 3'b110
	} nso_fmt_e;

	// Per-output driver configuration
	typedef struct packed {
		logic [1:0] drive;
		logic       invert;
		logic [2:0] fmt;
	} nso_out_cfg_s;

	typedef logic [39:0] nso_word_t;
	typedef logic [2:0]  nso_src_t;

endpackage

// [logic/nso_step_edge.sv]
`timescale 1ns/1ps
// Turns every edge of the selected phase-step control into one pulse
module nso_step_edge #(
	parameter int GPIO_N = 4
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire nso_pkg::nso_src_t src_sel,
	input  wire logic              reg_level,
	input  wire logic [GPIO_N-1:0] gpio_in,
	output logic                   step_pulse
);
	import nso_pkg::*;

	typedef struct packed {
		logic [GPIO_N-1:0] meta;
		logic [GPIO_N-1:0] sync;
		nso_src_t          sel_prev;
		logic              level_prev;
		logic              pulse;
	} nso_edge_s;

	nso_edge_s s_r;
	nso_edge_s s_nxt;
	logic      level;

	// ---------------------------------------------------------------
	// Synchronise, select and detect both edges
	// ---------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		level = 1'b0;
		s_nxt.meta = gpio_in;
		s_nxt.sync = s_r.meta;
		if (src_sel == 3'h0) begin
			level = reg_level;
		end else if (int'(src_sel) <= GPIO_N) begin
			level = s_r.sync[int'(src_sel) - 1];
		end
		s_nxt.level_prev = level;
		s_nxt.sel_prev = src_sel;
		// A source change only reloads the reference level
		s_nxt.pulse = (src_sel == s_r.sel_prev) && (level != s_r.level_prev);
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign step_pulse = s_r.pulse;

endmodule

// [logic/nso_synth_ctrl.sv]
// Functional notes
// - Oscillator mode: holdover, frequency from software word
// - Nominal word gives zero offset output
// - Mode changes never jump output phase
// - Synthesizer runs only while enable set
// - Feedback ratio: integer plus scaled remainder
// - Two fast dividers, each own field
// - Two live lock status bits
// - Phase steps of one eighth cycle
// - Step sources: register bit or GPIO
// - Step on every edge of control
// - Each step moves both fast dividers
// - Three output pairs, six CMOS outputs
// - Output runs when format and enable set
// - Format selects CML, HSTL, CMOS, off
// - CMOS negative pin off, same, inverted
// - Invert bit inverts driver clock
// - Four drive strengths for CMOS/HSTL
`timescale 1ns/1ps
`include "nso_defines.svh"
module nso_synth_ctrl #(
	parameter logic [39:0] NOMINAL_WORD = 40'h80_0000_0000,
	parameter int          OUT_N        = 3,
	parameter int          GPIO_N       = 4
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire nso_pkg::nso_word_t dpll_freq_word,
	input  wire logic              synth_lock_a_in,
	input  wire logic              synth_lock_b_in,
	input  wire logic [GPIO_N-1:0] gpio_in,
	input  wire logic [OUT_N-1:0]  div_clk_in,
	output logic                   dpll_holdover,
	output nso_pkg::nso_word_t     synth_freq_word,
	output logic                   nco_clk_out,
	output logic                   synth_on,
	output logic                   synth_restart,
	output logic      [39:0]       fb_int_out,
	output logic      [6:0]        fb_int_whole,
	output logic      [31:0]       fb_rem_out,
	output logic      [31:0]       fb_den_out,
	output logic      [5:0]        fb_frac_bits,
	output logic      [3:0]        fast_div_one_out,
	output logic      [3:0]        fast_div_two_out,
	output logic                   phase_inc_step,
	output logic                   phase_dec_step,
	output logic      [OUT_N-1:0]  out_div_run,
	output logic      [OUT_N-1:0]  out_pos_pin,
	output logic      [OUT_N-1:0]  out_pos_oe,
	output logic      [OUT_N-1:0]  out_neg_pin,
	output logic      [OUT_N-1:0]  out_neg_oe,
	output logic      [OUT_N-1:0]  out_half_swing,
	output logic      [OUT_N-1:0]  out_low_power,
	output logic      [2*OUT_N-1:0] out_drive
);
	import nso_pkg::*;

	typedef struct packed {
		nso_word_t                nco_freq_word;
		logic                     synth_on_bit;
		logic                     nco_mode;
		logic [39:0]              fb_div_integer;
		logic [31:0]              fb_div_remainder;
		logic [31:0]              fb_div_denominator;
		logic [5:0]               fb_div_point_pos;
		logic [3:0]               fast_divider_one;
		logic [3:0]               fast_divider_two;
		nso_src_t                 phase_dec_source;
		nso_src_t                 phase_inc_source;
		logic                     phase_dec_bit;
		logic                     phase_inc_bit;
		logic [OUT_N-1:0]         out_divider_enable;
		nso_out_cfg_s [OUT_N-1:0] out_ctrl_two;
		logic                     synth_lock_a;
		logic                     synth_lock_b;
		logic [2:0]               phase_pos;
		logic                     pready;
		logic                     pslverr;
		logic [31:0]              prdata;
		logic                     holdover;
		nso_word_t                sfw;
		nso_word_t                acc;
		logic                     nco_clk;
		logic                     on_out;
		logic                     restart;
		logic [39:0]              fb_int;
		logic [6:0]               fb_whole;
		logic [31:0]              fb_rem;
		logic [31:0]              fb_den;
		logic [5:0]               fb_shift;
		logic [3:0]               hs1;
		logic [3:0]               hs2;
		logic                     inc_step;
		logic                     dec_step;
		logic [OUT_N-1:0]         div_run;
		logic [OUT_N-1:0]         pos_pin;
		logic [OUT_N-1:0]         pos_oe;
		logic [OUT_N-1:0]         neg_pin;
		logic [OUT_N-1:0]         neg_oe;
		logic [OUT_N-1:0]         half;
		logic [OUT_N-1:0]         lowp;
		logic [2*OUT_N-1:0]       drive;
	} nso_state_s;

	nso_state_s s_r;
	nso_state_s s_nxt;
	logic       inc_pulse;
	logic       dec_pulse;
	logic       setup;
	logic       wr;
	logic       mapped;
	logic [31:0] rdata;
	logic [2:0] fmt;
	logic       clk_v;
	logic [5:0] shift;

	// ---------------------------------------------------------------
	// Phase-step edge detectors
	// ---------------------------------------------------------------
	nso_step_edge #(.GPIO_N(GPIO_N)) u_inc_edge (
		.pclk       (pclk),
		.presetn    (presetn),
		.src_sel    (s_r.phase_inc_source),
		.reg_level  (s_r.phase_inc_bit),
		.gpio_in    (gpio_in),
		.step_pulse (inc_pulse)
	);

	nso_step_edge #(.GPIO_N(GPIO_N)) u_dec_edge (
		.pclk       (pclk),
		.presetn    (presetn),
		.src_sel    (s_r.phase_dec_source),
		.reg_level  (s_r.phase_dec_bit),
		.gpio_in    (gpio_in),
		.step_pulse (dec_pulse)
	);

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		setup = psel && !penable;
		wr = psel && penable && s_r.pready && pwrite;
		mapped = 1'b1;
		rdata = 32'h00000000;
		fmt = 3'h0;
		clk_v = 1'b0;
		shift = `NSO_FRAC_TOTAL - s_r.fb_div_point_pos;

		// Read decode
		case (paddr)
			`NSO_OFF_FREQ_LO:   rdata = s_r.nco_freq_word[31:0];
			`NSO_OFF_FREQ_HI:   rdata = {24'h000000, s_r.nco_freq_word[39:32]};
			`NSO_OFF_NOM_LO:    rdata = NOMINAL_WORD[31:0];
			`NSO_OFF_NOM_HI:    rdata = {24'h000000, NOMINAL_WORD[39:32]};
			`NSO_OFF_ENABLE:    rdata = {30'h00000000, s_r.nco_mode, s_r.synth_on_bit};
			`NSO_OFF_FBINT_LO:  rdata = s_r.fb_div_integer[31:0];
			`NSO_OFF_FBINT_HI:  rdata = {24'h000000, s_r.fb_div_integer[39:32]};
			`NSO_OFF_FBREM:     rdata = s_r.fb_div_remainder;
			`NSO_OFF_FBDEN:     rdata = s_r.fb_div_denominator;
			`NSO_OFF_FBBP:      rdata = {26'h0000000, s_r.fb_div_point_pos};
			`NSO_OFF_CTRL_TWO:  rdata = {24'h000000, s_r.fast_divider_two, s_r.fast_divider_one};
			`NSO_OFF_STATUS:    rdata = {30'h00000000, s_r.synth_lock_b, s_r.synth_lock_a};
			`NSO_OFF_CTRL_FOUR: rdata = {22'h000000, s_r.phase_inc_bit, s_r.phase_dec_bit,
				1'b0, s_r.phase_inc_source, 1'b0, s_r.phase_dec_source};
			`NSO_OFF_OUT_EN:    rdata = 32'(s_r.out_divider_enable);
			`NSO_OFF_PHASE:     rdata = {29'h00000000, s_r.phase_pos};
			default: begin
				mapped = 1'b0;
				for (int i = 0; i < OUT_N; i++) begin
					if (paddr == 8'(`NSO_OFF_OCFG0 + 4 * i)) begin
						mapped = 1'b1;
						rdata = 32'(s_r.out_ctrl_two[i]);
					end
				end
			end
		endcase

		// Bus answer: one wait-free access phase after each setup
		s_nxt.pready = setup;
		s_nxt.pslverr = setup && !mapped;
		if (setup) begin
			s_nxt.prdata = rdata;
		end

		// Register writes at the completing access edge
		if (wr) begin
			case (paddr)
				`NSO_OFF_FREQ_LO:   s_nxt.nco_freq_word[31:0] = pwdata;
				`NSO_OFF_FREQ_HI:   s_nxt.nco_freq_word[39:32] = pwdata[7:0];
				`NSO_OFF_ENABLE: begin
					s_nxt.synth_on_bit = pwdata[`NSO_EN_SYNTH_BIT];
					s_nxt.nco_mode = pwdata[`NSO_EN_NCO_BIT];
				end
				`NSO_OFF_FBINT_LO:  s_nxt.fb_div_integer[31:0] = pwdata;
				`NSO_OFF_FBINT_HI:  s_nxt.fb_div_integer[39:32] = pwdata[7:0];
				`NSO_OFF_FBREM:     s_nxt.fb_div_remainder = pwdata;
				`NSO_OFF_FBDEN:     s_nxt.fb_div_denominator = pwdata;
				`NSO_OFF_FBBP:      s_nxt.fb_div_point_pos = pwdata[5:0];
				`NSO_OFF_CTRL_TWO: begin
					s_nxt.fast_divider_one = pwdata[`NSO_HS1_LSB +: 4];
					s_nxt.fast_divider_two = pwdata[`NSO_HS2_LSB +: 4];
				end
				`NSO_OFF_CTRL_FOUR: begin
					s_nxt.phase_dec_source = pwdata[`NSO_DEC_SRC_LSB +: 3];
					s_nxt.phase_inc_source = pwdata[`NSO_INC_SRC_LSB +: 3];
					s_nxt.phase_dec_bit = pwdata[`NSO_DEC_BIT];
					s_nxt.phase_inc_bit = pwdata[`NSO_INC_BIT];
				end
				`NSO_OFF_OUT_EN:    s_nxt.out_divider_enable = pwdata[OUT_N-1:0];
				default: begin
					for (int i = 0; i < OUT_N; i++) begin
						if (paddr == 8'(`NSO_OFF_OCFG0 + 4 * i)) begin
							s_nxt.out_ctrl_two[i] = nso_out_cfg_s'(pwdata[5:0]);
						end
					end
				end
			endcase
		end

		// Live lock status
		s_nxt.synth_lock_a = synth_lock_a_in;
		s_nxt.synth_lock_b = synth_lock_b_in;

		// Frequency source: software word in oscillator mode, else tracked word
		s_nxt.holdover = s_r.nco_mode;
		s_nxt.sfw = s_r.nco_mode ? s_r.nco_freq_word : dpll_freq_word;
		// Accumulator is never reloaded, so a mode change keeps phase
		s_nxt.acc = s_r.acc + s_r.sfw;
		s_nxt.nco_clk = s_r.acc[39];

		// Synthesizer enable and restart on a 0 to 1 change
		s_nxt.on_out = s_r.synth_on_bit;
		s_nxt.restart = s_r.synth_on_bit && !s_r.on_out;
		if (s_r.synth_on_bit && !s_r.on_out) begin
			// Feedback settings take effect at each restart
			s_nxt.fb_int = s_r.fb_div_integer;
			s_nxt.fb_whole = 7'(s_r.fb_div_integer >> shift);
			s_nxt.fb_rem = s_r.fb_div_remainder;
			s_nxt.fb_den = s_r.fb_div_denominator;
			s_nxt.fb_shift = shift;
		end
		s_nxt.hs1 = s_r.fast_divider_one;
		s_nxt.hs2 = s_r.fast_divider_two;

		// Phase steps of 1/8 VCO cycle; opposite steps together cancel
		s_nxt.inc_step = s_r.synth_on_bit && inc_pulse && !dec_pulse;
		s_nxt.dec_step = s_r.synth_on_bit && dec_pulse && !inc_pulse;
		if (s_nxt.inc_step) begin
			s_nxt.phase_pos = s_r.phase_pos + 3'h1;
		end else if (s_nxt.dec_step) begin
			s_nxt.phase_pos = s_r.phase_pos - 3'h1;
		end

		// Output drivers
		for (int i = 0; i < OUT_N; i++) begin
			fmt = s_r.out_ctrl_two[i].fmt;
			clk_v = div_clk_in[i] ^ s_r.out_ctrl_two[i].invert;
			s_nxt.div_run[i] = s_r.out_divider_enable[i];
			s_nxt.pos_oe[i] = 1'b1;
			s_nxt.pos_pin[i] = s_r.out_divider_enable[i] && clk_v;
			s_nxt.neg_oe[i] = 1'b1;
			s_nxt.neg_pin[i] = s_r.out_divider_enable[i] && !clk_v;
			s_nxt.half[i] = 1'b0;
			s_nxt.lowp[i] = 1'b0;
			s_nxt.drive[2*i +: 2] = 2'h0;
			case (fmt)
				NSO_FMT_CML_FULL: ;
				NSO_FMT_CML_HALF: s_nxt.half[i] = 1'b1;
				NSO_FMT_HSTL:     s_nxt.drive[2*i +: 2] = s_r.out_ctrl_two[i].drive;
				NSO_FMT_CMOS_P: begin
					s_nxt.neg_oe[i] = 1'b0;
					s_nxt.neg_pin[i] = 1'b0;
					s_nxt.drive[2*i +: 2] = s_r.out_ctrl_two[i].drive;
				end
				NSO_FMT_CMOS_PAIR: begin
					s_nxt.neg_pin[i] = s_nxt.pos_pin[i];
					s_nxt.drive[2*i +: 2] = s_r.out_ctrl_two[i].drive;
				end
				NSO_FMT_CMOS_INV:  s_nxt.drive[2*i +: 2] = s_r.out_ctrl_two[i].drive;
				default: begin
					// Disabled: both pins released, driver in low power
					s_nxt.pos_oe[i] = 1'b0;
					s_nxt.pos_pin[i] = 1'b0;
					s_nxt.neg_oe[i] = 1'b0;
					s_nxt.neg_pin[i] = 1'b0;
					s_nxt.lowp[i] = 1'b1;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.nco_freq_word <= NOMINAL_WORD;
			s_r.fb_div_point_pos <= `NSO_RST_FBBP;
			s_r.fb_div_denominator <= `NSO_RST_FBDEN;
			s_r.fast_divider_one <= `NSO_RST_HSDIV;
			s_r.fast_divider_two <= `NSO_RST_HSDIV;
			s_r.lowp <= '1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs straight from the state register
	// ---------------------------------------------------------------
	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign dpll_holdover = s_r.holdover;
	assign synth_freq_word = s_r.sfw;
	assign nco_clk_out = s_r.nco_clk;
	assign synth_on = s_r.on_out;
	assign synth_restart = s_r.restart;
	assign fb_int_out = s_r.fb_int;
	assign fb_int_whole = s_r.fb_whole;
	assign fb_rem_out = s_r.fb_rem;
	assign fb_den_out = s_r.fb_den;
	assign fb_frac_bits = s_r.fb_shift;
	assign fast_div_one_out = s_r.hs1;
	assign fast_div_two_out = s_r.hs2;
	assign phase_inc_step = s_r.inc_step;
	assign phase_dec_step = s_r.dec_step;
	assign out_div_run = s_r.div_run;
	assign out_pos_pin = s_r.pos_pin;
	assign out_pos_oe = s_r.pos_oe;
	assign out_neg_pin = s_r.neg_pin;
	assign out_neg_oe = s_r.neg_oe;
	assign out_half_swing = s_r.half;
	assign out_low_power = s_r.lowp;
	assign out_drive = s_r.drive;

endmodule

// [verif/nso_synth_ctrl_asserts.sv]
`timescale 1ns/1ps
module nso_synth_ctrl_chk #(
	parameter int OUT_N = 3
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire nso_pkg::nso_word_t dpll_freq_word,
	input wire logic               dpll_holdover,
	input wire nso_pkg::nso_word_t synth_freq_word,
	input wire logic               synth_on,
	input wire logic               synth_restart,
	input wire logic [5:0]         fb_frac_bits,
	input wire logic               phase_inc_step,
	input wire logic               phase_dec_step,
	input wire logic [OUT_N-1:0]   out_div_run,
	input wire logic [OUT_N-1:0]   out_pos_pin,
	input wire logic [OUT_N-1:0]   out_pos_oe,
	input wire logic [OUT_N-1:0]   out_neg_oe,
	input wire logic [OUT_N-1:0]   out_low_power
);
	logic [1:0] live_r;

	// Counts edges since reset release, so reset values are not judged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			live_r <= 2'h0;
		else if (live_r != 2'h3)
			live_r <= live_r + 2'h1;
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ---------------------------------------------------------------
	// Bus, restart, steps, outputs
	// ---------------------------------------------------------------
	apb_answer_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	restart_rise_a: assert property ($rose(synth_on) |-> synth_restart)
		else $error("enable rise without restart");
	restart_once_a: assert property (synth_restart |-> synth_on ##1 !synth_restart)
		else $error("restart pulse malformed");
	fb_hold_a: assert property (live_r == 2'h3 && $changed(fb_frac_bits) |-> synth_restart)
		else $error("divider moved without restart");
	step_cancel_a: assert property (!(phase_inc_step && phase_dec_step))
		else $error("both step pulses at once");
	step_on_a: assert property (phase_inc_step || phase_dec_step |-> synth_on)
		else $error("step while synthesizer off");
	word_track_a: assert property (live_r == 2'h3 && !dpll_holdover
		|-> synth_freq_word == $past(dpll_freq_word))
		else $error("tracked word not used");
	power_oe_a: assert property (out_low_power == ~out_pos_oe)
		else $error("low power and drive disagree");
	pin_gate_a: assert property ((out_pos_pin & ~out_div_run) == '0)
		else $error("pin toggles with divider off");
	neg_oe_a: assert property ((out_neg_oe & ~out_pos_oe) == '0)
		else $error("negative pin on with pair off");

	cov_restart: cover property (synth_restart);
	cov_inc: cover property (phase_inc_step);
	cov_dec: cover property (phase_dec_step);
	cov_hold: cover property ($rose(dpll_holdover));
endmodule

bind nso_synth_ctrl nso_synth_ctrl_chk #(.OUT_N(OUT_N)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .dpll_freq_word(dpll_freq_word), .dpll_holdover(dpll_holdover),
	.synth_freq_word(synth_freq_word), .synth_on(synth_on), .synth_restart(synth_restart),
	.fb_frac_bits(fb_frac_bits), .phase_inc_step(phase_inc_step),
	.phase_dec_step(phase_dec_step), .out_div_run(out_div_run), .out_pos_pin(out_pos_pin),
	.out_pos_oe(out_pos_oe), .out_neg_oe(out_neg_oe), .out_low_power(out_low_power)
);

// [verif/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import nso_pkg::*;
	localparam logic [39:0] NOM = 40'h7F_FFC0_0001; // Nominal word just under half scale
	localparam logic [7:0]  RA [0:6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20, 8'h24, 8'h28};
	localparam logic [31:0] RV [0:6] = '{NOM[31:0], {24'h0, NOM[39:32]}, NOM[31:0],
		{24'h0, NOM[39:32]}, 32'h1, 32'h9, 32'h66};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, seed, c4, en, r, dn;
	logic [31:0] cf [0:2];
	nso_word_t   dfw, sfw, nw, w;
	logic        lk_a, lk_b, hold, s_on, s_rst, p_inc, p_dec, nco;
	logic [6:0]  fbw;
	logic [3:0]  gpio, hs1, hs2;
	logic [2:0]  dclk, run, pp, poe, pn, noe, half, lp, pos;
	logic [39:0] fbi;
	logic [31:0] fbr, fbd;
	logic [5:0]  fbf, drv, bp;
	logic [4:0]  x;
	int          mismatches, num_checks, inc_n, dec_n, i0, d0, n;

	nso_synth_ctrl #(.NOMINAL_WORD(NOM)) u_nso_synth_ctrl (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dpll_freq_word(dfw), .synth_lock_a_in(lk_a), .synth_lock_b_in(lk_b), .gpio_in(gpio),
		.div_clk_in(dclk), .dpll_holdover(hold), .synth_freq_word(sfw), .nco_clk_out(nco),
		.synth_on(s_on), .synth_restart(s_rst), .fb_int_out(fbi), .fb_int_whole(fbw),
		.fb_rem_out(fbr), .fb_den_out(fbd), .fb_frac_bits(fbf), .fast_div_one_out(hs1),
		.fast_div_two_out(hs2), .phase_inc_step(p_inc), .phase_dec_step(p_dec),
		.out_div_run(run), .out_pos_pin(pp), .out_pos_oe(poe), .out_neg_pin(pn),
		.out_neg_oe(noe), .out_half_swing(half), .out_low_power(lp), .out_drive(drv)
	);

	// Clock and step tallies
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		inc_n <= inc_n + int'(p_inc === 1'b1);
		dec_n <= dec_n + int'(p_dec === 1'b1);
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Software word for an offset in ppm, always scaled from nominal
	function automatic logic [39:0] nco_word(input int ppm);
		longint p;
		p = longint'(NOM) * ppm;
		p = p + (p < 0 ? -500000 : 500000);
		return 40'(longint'(NOM) + p / 1000000);
	endfunction

	// Expected {pos oe, neg oe, half swing, pos pin, neg pin} of one output
	function automatic logic [4:0] expo(input logic [31:0] c, input logic e, input logic ck);
		logic [2:0] fm;
		logic       p;
		fm = c[2:0];
		p = e & (ck ^ c[3]);
		return {fm inside {[3'h1:3'h6]}, fm inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h6},
			fm == 3'h2, p, e & (fm == 3'h5 ? p : ~p)};
	endfunction

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic wait_n(input int c);
		repeat (c) @(posedge pclk);
	endtask

	// One APB transfer followed by one idle cycle
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			mismatches++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	initial begin
		{pclk, presetn, psel, penable, pwrite, lk_a, lk_b} = '0;
		{paddr, pwdata, gpio, dclk, dfw} = '0;
		{mismatches, num_checks, inc_n, dec_n} = '0;
		seed = 32'd28647;
		c4 = 32'h0;
		pos = 3'h0;
		wait_n(20);
		chk(lp, 3'h7);
		presetn <= 1'b1;
		wait_n(2);
		// Reset values, read-only nominal word, unmapped place
		apb(1'b1, 8'h08, rnd());
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, RA[i], 32'h0);
			chk(rd, RV[i]);
		end
		apb(1'b1, 8'h7C, rnd());
		chk(err, 1'b1);
		apb(1'b0, 8'h48, 32'h0);
		chk({err, rd}, {1'b1, 32'h0});
		// Tracking, oscillator mode, nominal word, back to tracking
		dfw <= 40'({rnd(), rnd()});
		wait_n(3);
		chk({hold, sfw}, {1'b0, dfw});
		nw = nco_word(int'(rnd() % 1001) - 500);
		apb(1'b1, 8'h00, nw[31:0]);
		apb(1'b1, 8'h04, {24'h0, nw[39:32]});
		apb(1'b1, 8'h10, 32'h2);
		dfw <= ~dfw;
		wait_n(3);
		chk({hold, sfw}, {1'b1, nw});
		apb(1'b1, 8'h00, NOM[31:0]);
		apb(1'b1, 8'h04, {24'h0, NOM[39:32]});
		wait_n(2);
		chk(sfw, NOM);
		// Nominal word is just under half scale: the clock is high about half the time
		n = 0;
		repeat (64) begin
			@(posedge pclk);
			n += int'(nco === 1'b1);
		end
		chk(64'(n >= 31 && n <= 33), 64'h1);
		apb(1'b1, 8'h10, 32'h0);
		wait_n(3);
		chk({hold, sfw}, {1'b0, dfw});
		// Feedback divider restart
		w = 40'({rnd(), rnd()});
		r = rnd();
		dn = rnd() | 32'h1;
		bp = 6'(rnd() % 22);
		apb(1'b1, 8'h14, w[31:0]);
		apb(1'b1, 8'h18, {24'h0, w[39:32]});
		apb(1'b1, 8'h1C, r);
		apb(1'b1, 8'h20, dn);
		apb(1'b1, 8'h24, {26'h0, bp});
		chk(fbf, 6'h0);
		apb(1'b1, 8'h10, 32'h1);
		n = 0;
		while (s_rst !== 1'b1 && n < 4) begin
			@(posedge pclk);
			n++;
		end
		chk({s_on, s_rst, fbi}, {2'h3, w});
		chk({fbr, fbd}, {r, dn});
		chk({fbf, fbw}, {6'h21 - bp, 7'(w >> (6'h21 - bp))});
		// Fast dividers and live lock status
		c4 = rnd() & 32'hFF;
		apb(1'b1, 8'h28, c4);
		wait_n(2);
		chk({hs1, hs2}, {c4[3:0], c4[7:4]});
		for (int k = 0; k < 4; k++) begin
			lk_a <= k[0];
			lk_b <= k[1];
			wait_n(3);
			apb(1'b0, 8'h2C, 32'h0);
			chk(rd[1:0], k[1:0]);
		end
		// Phase steps from every source, both edges, source swaps
		c4 = 32'h0;
		for (int s = 0; s < 5; s++) begin
			for (int d = 0; d < 2; d++) begin
				c4 = (c4 & 32'h300) | 32'(d ? s << 4 : s);
				apb(1'b1, 8'h30, c4);
				wait_n(8);
				i0 = inc_n;
				d0 = dec_n;
				repeat (2) begin
					if (s == 0) begin
						c4 = c4 ^ (d ? 32'h200 : 32'h100);
						apb(1'b1, 8'h30, c4);
					end else begin
						gpio[s-1] <= ~gpio[s-1];
					end
					wait_n(8);
				end
				chk(64'(inc_n - i0), d ? 64'h2 : 64'h0);
				chk(64'(dec_n - d0), d ? 64'h0 : 64'h2);
				pos = d ? pos + 3'h2 : pos - 3'h2;
				apb(1'b0, 8'h44, 32'h0);
				chk(rd[2:0], pos);
			end
		end
		// Every format on rotating outputs, random invert, drive and enables
		for (int f = 0; f < 8; f++) begin
			en = rnd();
			for (int i = 0; i < 3; i++) begin
				cf[i] = (rnd() & 32'h38) | 32'((f + i) % 8);
				apb(1'b1, 8'(8'h38 + 4 * i), cf[i]);
			end
			apb(1'b1, 8'h34, en & 32'h7);
			for (int k = 0; k < 2; k++) begin
				dclk <= 3'(rnd());
				wait_n(3);
				for (int i = 0; i < 3; i++) begin
					x = expo(cf[i], en[i], dclk[i]);
					chk({poe[i], noe[i], half[i], lp[i]}, {x[4:2], ~x[4]});
					chk({run[i], drv[2*i+:2]}, {en[i],
						(cf[i][2:0] inside {[3'h3:3'h6]}) ? cf[i][5:4] : 2'h0});
					if (x[4])
						chk(pp[i], x[1]);
					if (x[3])
						chk(pn[i], x[0]);
				end
			end
		end
		end_sim();
	end
endmodule
